// ### logic/oag_top.sv
// operand address generator: sequences register reads, access, write-back
// Contract
// - direct operands address the 256-byte register file, never memory
// - up to three direct registers, each aligned for its operand size
// - only one immediate, indirect or indexed operand; the rest are direct
// - indirect address comes from a word-aligned 16-bit pointer register
// - post-increment adds one for byte, two for word destinations
// - specifier low bit selects post-increment; register stays word-aligned
// - extended indirect uses a word-aligned 24-bit pointer register
// - extended load reads memory, extended store writes memory
// - stack-relative push and pop use the stack pointer before update
// - stack pointer accepted as indirect pointer and short-index base
// - short index adds an 8-bit constant to a word base register
// - long index adds a 16-bit constant to a word offset register
// - extended index adds 24-bit offset to double-word-aligned 24-bit base
// - zero index uses the 16-bit constant itself as the address
// - extended zero index uses 24-bit constant; zero register reads zero
// - only the low 20 address bits reach the pins
module oag_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // operand request from the decoder
  input wire logic req_valid,
  output logic req_ready,
  input wire oag_pkg::oag_mode_e req_mode,
  input wire oag_pkg::oag_size_e req_size,
  input wire logic req_ext,
  input wire logic req_store,
  input wire logic [1:0] req_nregs,
  input wire logic [7:0] req_reg0,
  input wire logic [7:0] req_reg1,
  input wire logic [7:0] req_reg2,
  input wire logic [23:0] req_const,
  // completion
  output logic done,
  output logic done_err,
  output logic [23:0] ea,
  // register file
  output logic rf_rd_en,
  output logic [7:0] rf_rd_addr,
  input wire logic [31:0] rf_rd_data,
  output logic rf_wr_en,
  output logic [7:0] rf_wr_addr,
  output logic [23:0] rf_wr_data,
  output logic rf_wr_long,
  // memory controller
  output logic mem_req,
  output logic mem_we,
  output oag_pkg::oag_size_e mem_size,
  output logic [23:0] mem_addr,
  output logic [19:0] mem_pin_addr,
  input wire logic mem_done
);
  import oag_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_READ, S_CALC, S_MEM, S_WB} oag_state_e;

  oag_state_e st_q, st_d;
  oag_mode_e mode_q, mode_d;
  oag_size_e size_q, size_d;
  logic ext_q, ext_d, store_q, store_d, inc_q, inc_d, use_q, use_d;
  logic [7:0] ptr_q, ptr_d;
  logic [23:0] const_q, const_d, ea_q, ea_d, nxt_q, nxt_d;
  logic done_q, done_d, err_q, err_d, memr_q, memr_d, wb_q, wb_d;
  logic bad;
  logic [2:0] dir_ok;

  oag_calc_if cif ();

  oag_ea_calc u_calc (
    .cif(cif)
  );

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      dir_ok[i] = 1'b1;
    end
    if (req_nregs > 2'd0) dir_ok[0] = oag_aligned(req_reg0, req_size);
    if (req_nregs > 2'd1) dir_ok[1] = oag_aligned(req_reg1, req_size);
    if (req_nregs > 2'd2) dir_ok[2] = oag_aligned(req_reg2, req_size);
  end

  always_comb begin
    bad = ~&dir_ok;
    if (req_mode != OAG_DIRECT && req_nregs > MAX_DIRECT_MEMOP) bad = 1'b1;
    // extended forms exist only for indirect and long index
    if (req_ext && req_mode != OAG_INDIR && req_mode != OAG_LONG_IDX) begin
      bad = 1'b1;
    end
    // index register must be a word
    if ((req_mode == OAG_SHORT_IDX || (req_mode == OAG_LONG_IDX && !req_ext))
        && req_reg2[0]) bad = 1'b1;
    if (req_mode == OAG_LONG_IDX && req_ext
        && !oag_aligned(req_reg2, OAG_DWORD)) bad = 1'b1;
  end

  // calc gets the pointer value only while read data are valid
  always_comb begin
    cif.mode = mode_q;
    cif.size = size_q;
    cif.ext = ext_q;
    cif.konst = const_q;
    cif.ptr_val = (st_q == S_CALC && use_q) ? rf_rd_data : 32'h0000_0000;
  end

  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    size_d = size_q;
    ext_d = ext_q;
    store_d = store_q;
    inc_d = inc_q;
    use_d = use_q;
    ptr_d = ptr_q;
    const_d = const_q;
    ea_d = ea_q;
    nxt_d = nxt_q;
    done_d = 1'b0;
    err_d = 1'b0;
    memr_d = memr_q;
    wb_d = 1'b0;
    case (st_q)
      S_IDLE: begin
        if (req_valid) begin
          mode_d = req_mode;
          size_d = req_size;
          ext_d = req_ext;
          store_d = req_store;
          const_d = req_const;
          // low bit is post-increment, register is word address
          ptr_d = oag_ptr_reg(req_reg2);
          inc_d = (req_mode == OAG_INDIR) & req_reg2[0];
          // zero register index needs no read, value is zero
          use_d = (req_mode == OAG_INDIR || req_mode == OAG_SHORT_IDX ||
                   (req_mode == OAG_LONG_IDX && req_reg2 != ZERO_REG_ADDR));
          if (bad) begin
            done_d = 1'b1;
            err_d = 1'b1;
          end else if (use_d) begin
            st_d = S_READ;
          end else begin
            st_d = S_CALC;
          end
        end
      end
      S_READ: begin
        st_d = S_CALC;
      end
      S_CALC: begin
        ea_d = cif.ea;
        nxt_d = cif.ptr_next;
        // direct and immediate never touch memory
        if (mode_q == OAG_DIRECT || mode_q == OAG_IMMED) begin
          done_d = 1'b1;
          st_d = S_IDLE;
        end else begin
          memr_d = 1'b1;
          st_d = S_MEM;
        end
      end
      S_MEM: begin
        if (mem_done) begin
          memr_d = 1'b0;
          // write-back only after the access ends
          if (inc_q) begin
            wb_d = 1'b1;
            st_d = S_WB;
          end else begin
            done_d = 1'b1;
            st_d = S_IDLE;
          end
        end
      end
      S_WB: begin
        done_d = 1'b1;
        st_d = S_IDLE;
      end
      default: begin
        st_d = S_IDLE;
        memr_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= S_IDLE;
      mode_q <= OAG_DIRECT;
      size_q <= OAG_BYTE;
      ext_q <= 1'b0;
      store_q <= 1'b0;
      inc_q <= 1'b0;
      use_q <= 1'b0;
      ptr_q <= ZERO_REG_ADDR;
      const_q <= 24'h00_0000;
      ea_q <= 24'h00_0000;
      nxt_q <= 24'h00_0000;
      done_q <= 1'b0;
      err_q <= 1'b0;
      memr_q <= 1'b0;
      wb_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      size_q <= size_d;
      ext_q <= ext_d;
      store_q <= store_d;
      inc_q <= inc_d;
      use_q <= use_d;
      ptr_q <= ptr_d;
      const_q <= const_d;
      ea_q <= ea_d;
      nxt_q <= nxt_d;
      done_q <= done_d;
      err_q <= err_d;
      memr_q <= memr_d;
      wb_q <= wb_d;
    end
  end

  assign req_ready = (st_q == S_IDLE);
  assign done = done_q;
  assign done_err = err_q;
  assign ea = ea_q;
  // pointer read once, before any stack update
  assign rf_rd_en = (st_q == S_READ);
  assign rf_rd_addr = ptr_q;
  assign rf_wr_en = wb_q;
  assign rf_wr_addr = ptr_q;
  assign rf_wr_data = nxt_q;
  assign rf_wr_long = ext_q;
  // store direction drives the write strobe
  assign mem_req = memr_q;
  assign mem_we = store_q;
  assign mem_size = size_q;
  assign mem_addr = ea_q;
  // top four internal bits are not driven out
  assign mem_pin_addr = ea_q[PIN_AW-1:0];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic acc;
  assign acc = req_valid & req_ready;

  a_direct_no_mem: assert property (
    st_q == S_CALC && mode_q == OAG_DIRECT |=> !mem_req && done)
    else $error("direct operand reached memory");
  a_align_reject: assert property (
    acc && req_nregs != 2'd0 && !oag_aligned(req_reg0, req_size)
    |=> done && done_err)
    else $error("misaligned direct register accepted");
  a_one_memref: assert property (
    acc && req_mode != OAG_DIRECT && req_nregs == 2'd3 |=> done_err)
    else $error("second memory operand accepted");
  a_ptr_word: assert property (
    acc && req_mode == OAG_INDIR && !bad
    |=> rf_rd_en && rf_rd_addr == {$past(req_reg2[7:1]), 1'b0})
    else $error("pointer register not word aligned");
  a_postinc_step: assert property (
    rf_wr_en && !rf_wr_long
    |-> rf_wr_data[15:0] == 16'(ea_q[15:0] + oag_step(size_q)))
    else $error("post-increment step wrong");
  a_wb_after_mem: assert property (
    rf_wr_en |-> $past(mem_req && mem_done) && !mem_req)
    else $error("write-back before access completed");
  a_short_reach: assert property (
    st_q == S_CALC && mode_q == OAG_SHORT_IDX
    |=> mem_req && mem_addr == {HI_ZERO,
      16'($past(rf_rd_data[15:0]) + {HI_ZERO, $past(const_q[7:0])})})
    else $error("short index address wrong");
  a_ext_index: assert property (
    st_q == S_CALC && mode_q == OAG_LONG_IDX && ext_q && use_q
    |=> mem_addr == 24'($past(rf_rd_data[23:0]) + $past(const_q)))
    else $error("extended index address wrong");
  a_zero_idx: assert property (
    acc && !bad && req_mode == OAG_LONG_IDX && req_reg2 == ZERO_REG_ADDR
    |-> ##2 mem_req && mem_addr == ($past(req_ext, 2) ? $past(req_const, 2)
        : {HI_ZERO, $past(req_const[15:0], 2)}))
    else $error("zero index address wrong");

  c_postinc: cover property (rf_wr_en);
  c_ext_store: cover property (mem_req && mem_we && ext_q);
  c_reject: cover property (done && done_err);
endmodule : oag_top

// ### logic/oag_pkg.sv
// shared constants, types and decode functions of the operand address unit
package oag_pkg;
  localparam int RF_AW = 8;
  localparam int IA_W = 24;
  localparam int PIN_AW = 20;
  localparam int RD_W = 32;
  localparam logic [7:0] ZERO_REG_ADDR = 8'h00;
  localparam logic [7:0] SP_REG_ADDR = 8'h18;
  localparam logic [23:0] STEP_BYTE = 24'h00_0001;
  localparam logic [23:0] STEP_WORD = 24'h00_0002;
  localparam logic [7:0] HI_ZERO = 8'h00;
  localparam logic [1:0] MAX_DIRECT_MEMOP = 2'h2;

  typedef enum logic [2:0] {
    OAG_DIRECT,
    OAG_IMMED,
    OAG_INDIR,
    OAG_SHORT_IDX,
    OAG_LONG_IDX
  } oag_mode_e;

  typedef enum logic [1:0] {
    OAG_BYTE,
    OAG_WORD,
    OAG_DWORD
  } oag_size_e;

  function automatic logic oag_aligned(input logic [7:0] a,
                                       input oag_size_e s);
    case (s)
      OAG_BYTE: return 1'b1;
      OAG_WORD: return ~a[0];
      default: return a[1:0] == 2'b00;
    endcase
  endfunction : oag_aligned

  // low bit of a pointer specifier is the post-increment flag
  function automatic logic [7:0] oag_ptr_reg(input logic [7:0] r);
    return {r[7:1], 1'b0};
  endfunction : oag_ptr_reg

  function automatic logic [23:0] oag_step(input oag_size_e s);
    return (s == OAG_BYTE) ? STEP_BYTE : STEP_WORD;
  endfunction : oag_step
endpackage : oag_pkg

// ### logic/oag_calc_if.sv
// carrier between the sequencer and the address adder
interface oag_calc_if;
  import oag_pkg::*;
  oag_mode_e mode;
  oag_size_e size;
  logic ext;
  logic [31:0] ptr_val;
  logic [23:0] konst;
  logic [23:0] ea;
  logic [23:0] ptr_next;

  modport user (output mode, output size, output ext, output ptr_val,
                output konst, input ea, input ptr_next);
  modport calc (input mode, input size, input ext, input ptr_val,
                input konst, output ea, output ptr_next);
endinterface : oag_calc_if

// ### logic/oag_ea_calc.sv
// effective address adder for immediate, indirect and indexed operand modes; direct gives zero
module oag_ea_calc (
  // adder operands and results
  oag_calc_if.calc cif
);
  import oag_pkg::*;

  logic [15:0] sum16;
  logic [23:0] sum24;

  always_comb begin
    sum16 = 16'h0000;
    sum24 = 24'h00_0000;
    cif.ea = 24'h00_0000;
    case (cif.mode)
      OAG_IMMED: begin
        cif.ea = cif.konst;
      end
      OAG_INDIR: begin
        cif.ea = cif.ext ? cif.ptr_val[23:0] : {HI_ZERO, cif.ptr_val[15:0]};
      end
      OAG_SHORT_IDX: begin
        sum16 = cif.ptr_val[15:0] + {HI_ZERO, cif.konst[7:0]};
        cif.ea = {HI_ZERO, sum16};
      end
      OAG_LONG_IDX: begin
        sum16 = cif.ptr_val[15:0] + cif.konst[15:0];
        sum24 = cif.ptr_val[23:0] + cif.konst;
        cif.ea = cif.ext ? sum24 : {HI_ZERO, sum16};
      end
      default: begin
        cif.ea = 24'h00_0000;
      end
    endcase
  end

  always_comb begin
    cif.ptr_next = cif.ext ? 24'(cif.ptr_val[23:0] + oag_step(cif.size))
                 : {HI_ZERO, 16'(cif.ptr_val[15:0] + oag_step(cif.size))};
  end
endmodule : oag_ea_calc

// ### verif/oag_far_model.sv
// register file and memory controller model facing the address unit
module oag_far_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register file side
  input wire logic rf_rd_en,
  input wire logic [7:0] rf_rd_addr,
  output logic [31:0] rf_rd_data,
  input wire logic rf_wr_en,
  input wire logic [7:0] rf_wr_addr,
  input wire logic [23:0] rf_wr_data,
  input wire logic rf_wr_long,
  // memory side
  input wire logic mem_req,
  input wire logic [1:0] lat,
  output logic mem_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rf [256];
  logic [1:0] cnt_q;
  initial begin
    rf_rd_data = 32'h0000_0000;
    for (int i = 0; i < 256; i++) begin
      rf[i] = {~i[7:0], 4'h3, i[3:0], 4'h1, i[7:0], 4'h0};
    end
  end
  // stale read data toggles so a late sample never matches by luck
  always @(posedge mclk) begin
    if (rf_rd_en) begin
      rf_rd_data <= rf[rf_rd_addr];
    end else begin
      rf_rd_data <= ~rf_rd_data;
    end
    if (rf_wr_en && rf_wr_long) begin
      rf[rf_wr_addr][23:0] <= rf_wr_data;
    end else if (rf_wr_en) begin
      rf[rf_wr_addr][15:0] <= rf_wr_data[15:0];
    end
    cnt_q <= (rst || !mem_req || mem_done) ? 2'h0 : cnt_q + 2'h1;
  end
  // access ends after lat wait cycles, zero allowed
  assign mem_done = mem_req && (cnt_q == lat);
endmodule : oag_far_model

// ### verif/oag_tb_top.sv
// self-checking bench of the operand address generator
module oag_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import oag_pkg::*;
  logic mclk, rst, req_valid, req_ready, req_ext, req_store, done, done_err;
  oag_mode_e req_mode;
  oag_size_e req_size, mem_size;
  logic [1:0] req_nregs, lat;
  logic [7:0] req_reg0, req_reg1, req_reg2, rf_rd_addr, rf_wr_addr;
  logic [23:0] req_const, ea, rf_wr_data, mem_addr;
  logic [31:0] rf_rd_data, sh [256], r;
  logic rf_rd_en, rf_wr_en, rf_wr_long, mem_req, mem_we, mem_done;
  logic [19:0] mem_pin_addr;
  int error_cnt = 0, cmp_count = 0, tcnt = 0, seed = 32'hd839ccfd;
  oag_mode_e m;
  oag_size_e s;
  logic [23:0] k;
  logic [7:0] r2;
  logic x;

  oag_top DUT (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_mode(req_mode), .req_size(req_size),
    .req_ext(req_ext), .req_store(req_store), .req_nregs(req_nregs),
    .req_reg0(req_reg0), .req_reg1(req_reg1), .req_reg2(req_reg2),
    .req_const(req_const), .done(done), .done_err(done_err), .ea(ea),
    .rf_rd_en(rf_rd_en), .rf_rd_addr(rf_rd_addr),
    .rf_rd_data(rf_rd_data), .rf_wr_en(rf_wr_en),
    .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data),
    .rf_wr_long(rf_wr_long), .mem_req(mem_req), .mem_we(mem_we),
    .mem_size(mem_size), .mem_addr(mem_addr),
    .mem_pin_addr(mem_pin_addr), .mem_done(mem_done));
  oag_far_model far (.mclk(mclk), .rst(rst), .rf_rd_en(rf_rd_en),
    .rf_rd_addr(rf_rd_addr), .rf_rd_data(rf_rd_data), .rf_wr_en(rf_wr_en),
    .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data),
    .rf_wr_long(rf_wr_long), .mem_req(mem_req), .lat(lat),
    .mem_done(mem_done));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // hang guard, well above the expected run length
  always @(posedge mclk) begin
    tcnt++;
    if (tcnt == 30000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex,
      input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  function automatic logic exp_err(input oag_mode_e m, input oag_size_e s,
      input logic x, input logic [1:0] n, input logic [7:0] r0, r1, r2);
    logic e;
    logic [7:0] rr [3];
    rr = '{r0, r1, r2};
    e = (m != OAG_DIRECT) && (n == 2'h3);
    for (int i = 0; i < n; i++) begin
      e |= (s == OAG_WORD && rr[i][0]) || (s == OAG_DWORD && |rr[i][1:0]);
    end
    e |= x && m != OAG_INDIR && m != OAG_LONG_IDX;
    e |= !x && (m == OAG_SHORT_IDX || m == OAG_LONG_IDX) && r2[0];
    return e | (x && m == OAG_LONG_IDX && |r2[1:0]);
  endfunction : exp_err

  function automatic logic [23:0] exp_ea(input oag_mode_e m, input logic x,
      input logic [7:0] r2, input logic [23:0] k, input logic [31:0] v);
    logic [31:0] w;
    w = (r2 == ZERO_REG_ADDR) ? 32'h0000_0000 : v;
    case (m)
      OAG_IMMED: return k;
      OAG_INDIR: return x ? v[23:0] : {8'h00, v[15:0]};
      OAG_SHORT_IDX: return {8'h00, v[15:0] + {8'h00, k[7:0]}};
      OAG_LONG_IDX: return x ? k + w[23:0] : {8'h00, k[15:0] + w[15:0]};
      default: return 24'h00_0000;
    endcase
  endfunction : exp_ea

  task automatic do_op(input oag_mode_e m, input oag_size_e s, input logic x,
      input logic st, input logic [1:0] n, input logic [7:0] r0, r1, r2,
      input logic [23:0] k);
    logic err, inc, mop, rdx, md, pr, wok;
    logic [23:0] e, nv, ma;
    logic [7:0] p;
    int nrd, nwr, nmem;
    err = exp_err(m, s, x, n, r0, r1, r2);
    p = (m == OAG_INDIR) ? {r2[7:1], 1'b0} : r2;
    e = exp_ea(m, x, r2, k, sh[p]);
    inc = !err && m == OAG_INDIR && r2[0];
    nv = x ? e + ((s == OAG_BYTE) ? STEP_BYTE : STEP_WORD)
           : {8'h00, e[15:0] + ((s == OAG_BYTE) ? 16'h0001 : 16'h0002)};
    mop = !err && m != OAG_DIRECT && m != OAG_IMMED;
    rdx = mop && !(m == OAG_LONG_IDX && r2 == ZERO_REG_ADDR);
    {nrd, nwr, nmem, md, pr, wok} = '0;
    @(posedge mclk);
    #2;
    lat = 2'($random(seed));
    req_mode = m;
    req_size = s;
    req_ext = x;
    req_store = st;
    req_nregs = n;
    {req_reg0, req_reg1, req_reg2, req_const} = {r0, r1, r2, k};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) begin
      @(posedge mclk);
      #2;
    end
    @(posedge mclk);
    #2;
    req_valid = 1'b0;
    for (int c = 0; c < 40 && !done; c++) begin
      if (rf_rd_en) nrd++;
      if (rf_rd_en) chk("rf_rd_addr", p, rf_rd_addr);
      if (mem_req && !pr) nmem++;
      if (mem_req && !pr) ma = mem_addr;
      if (mem_req && !pr) chk("mem_pin_addr", e[19:0], mem_pin_addr);
      if (rf_wr_en) nwr++;
      if (rf_wr_en) wok = md;
      if (rf_wr_en) chk("wr_data", nv, rf_wr_data);
      if (rf_wr_en) chk("wr_addr", {x, p}, {rf_wr_long, rf_wr_addr});
      md |= mem_req && mem_done;
      pr = mem_req;
      @(posedge mclk);
      #2;
    end
    chk("done", 1'b1, done);
    chk("done_err", err, done_err);
    if (!err) chk("ea", e, ea);
    chk("rd/mem/wr counts", {1'b0, rdx, 1'b0, mop, 1'b0, inc},
        {nrd[1:0], nmem[1:0], nwr[1:0]});
    if (mop) chk("mem access", {e, st, s}, {ma, mem_we, mem_size});
    if (inc) chk("write after access", 1'b1, wok);
    if (inc && x) sh[p][23:0] = nv;
    if (inc && !x) sh[p][15:0] = nv[15:0];
  endtask : do_op

  initial begin
    for (int i = 0; i < 256; i++) begin
      sh[i] = {~i[7:0], 4'h3, i[3:0], 4'h1, i[7:0], 4'h0};
    end
    {rst, req_valid, req_ext, req_store, req_nregs, lat} = {1'b1, 7'h00};
    req_mode = OAG_DIRECT;
    req_size = OAG_BYTE;
    {req_reg0, req_reg1, req_reg2, req_const} = 48'h0000_0000_0000;
    repeat (4) @(posedge mclk);
    #2;
    rst = 1'b0;
    chk("reset outputs", 7'h40, {req_ready, done, done_err, rf_rd_en,
        rf_wr_en, mem_req, mem_we});
    do_op(OAG_DIRECT, OAG_WORD, 0, 0, 3, 8'h20, 8'h22, 8'h24, 0);
    do_op(OAG_DIRECT, OAG_BYTE, 0, 0, 3, 8'h21, 8'h23, 8'h25, 0);
    do_op(OAG_DIRECT, OAG_WORD, 0, 0, 2, 8'h20, 8'h23, 8'h00, 0);
    do_op(OAG_DIRECT, OAG_DWORD, 0, 0, 1, 8'h06, 8'h00, 8'h00, 0);
    do_op(OAG_INDIR, OAG_WORD, 0, 0, 3, 8'h20, 8'h24, 8'h30, 0);
    do_op(OAG_IMMED, OAG_WORD, 0, 0, 1, 8'h20, 0, 0, 24'h00_1234);
    do_op(OAG_SHORT_IDX, OAG_WORD, 1, 0, 0, 0, 0, 8'h30, 0);
    do_op(OAG_SHORT_IDX, OAG_WORD, 0, 0, 0, 0, 0, 8'h31, 0);
    do_op(OAG_LONG_IDX, OAG_WORD, 1, 0, 0, 0, 0, 8'h22, 0);
    do_op(OAG_INDIR, OAG_WORD, 0, 1, 1, 8'h20, 0, 8'h19, 0);
    do_op(OAG_INDIR, OAG_BYTE, 0, 0, 0, 0, 0, 8'h19, 0);
    do_op(OAG_SHORT_IDX, OAG_WORD, 0, 0, 0, 0, 0, SP_REG_ADDR,
          24'h00_00ff);
    do_op(OAG_LONG_IDX, OAG_BYTE, 0, 0, 0, 0, 0, 0, 24'h00_7ffe);
    do_op(OAG_LONG_IDX, OAG_WORD, 0, 1, 0, 0, 0, 8'h40, 24'h00_4000);
    do_op(OAG_LONG_IDX, OAG_WORD, 1, 0, 0, 0, 0, 0, 24'hff_2080);
    do_op(OAG_LONG_IDX, OAG_BYTE, 1, 1, 0, 0, 0, 8'h44, 24'hf1_0000);
    do_op(OAG_INDIR, OAG_WORD, 1, 0, 0, 0, 0, 8'h49, 0);
    do_op(OAG_INDIR, OAG_BYTE, 1, 1, 0, 0, 0, 8'h4d, 0);
    $display("test corners finished, mismatches %0d", error_cnt);
    for (int t = 0; t < 80; t++) begin
      r = $random(seed);
      k = 24'($random(seed));
      m = oag_mode_e'(r[2:0] % 3'h5);
      s = oag_size_e'((m == OAG_DIRECT) ? r[4:3] % 2'h3 : {1'b0, r[3]});
      x = r[5] && (m == OAG_INDIR || m == OAG_LONG_IDX);
      r2 = x ? {r[31:26], 2'b00}
             : ((m == OAG_INDIR) ? r[31:24] : {r[31:25], 1'b0});
      if (!x && m != OAG_IMMED) k = {9'h000, k[14:0]};
      do_op(m, s, x, r[7], (m == OAG_DIRECT) ? r[7:6] : {1'b0, r[6]},
            r[15:8] & 8'hfc, r[23:16] & 8'hfc, r2, k);
    end
    $display("test random finished, mismatches %0d", error_cnt);
    results();
  end
endmodule : oag_tb_top
